/* logic/tcc_map.svh */
// Register offsets, field positions, mode masks and reset values
`ifndef TCC_MAP_SVH
`define TCC_MAP_SVH
`define TCC_ADR_CAP_LO   4'h0
`define TCC_ADR_CAP_HI   4'h1
`define TCC_ADR_CMPA_LO  4'h2
`define TCC_ADR_CMPA_HI  4'h3
`define TCC_ADR_CMPB_LO  4'h4
`define TCC_ADR_CMPB_HI  4'h5
`define TCC_ADR_CMPC_LO  4'h6
`define TCC_ADR_CMPC_HI  4'h7
`define TCC_ADR_CTRL     4'h8
`define TCC_ADR_MODE     4'h9
`define TCC_ADR_COM      4'hA
`define TCC_ADR_FLAGS    4'hB
`define TCC_ADR_INTEN    4'hC
`define TCC_ADR_FORCE    4'hD
`define TCC_CTRL_FILT    0
`define TCC_CTRL_RISE    1
`define TCC_CTRL_ACMP    2
`define TCC_FLAG_CAP     0
`define TCC_FLAG_CMP0    1
`define TCC_COM_NONE     2'h0
`define TCC_COM_TOGGLE   2'h1
`define TCC_COM_CLEAR    2'h2
`define TCC_COM_SET      2'h3
`define TCC_PWM_MASK     16'hCFEE
`define TCC_TOPUPD_MASK  16'h0C0E
`define TCC_ICRTOP_MASK  16'h5500
`define TCC_FILT_LEN     4
`define TCC_BYTE_ZERO    8'h00
`define TCC_WORD_ZERO    16'h0000
`endif

/* logic/tcc_pkg.sv */
// Types shared by the capture/compare block
`default_nettype none
package tcc_pkg;
   typedef logic [3:0] tcc_mode_t;
   typedef logic [1:0] tcc_com_t;
   typedef struct packed {
      logic acmp_sel;
      logic rise;
      logic filt_en;
   } tcc_cap_cfg_s;
   typedef struct packed {
      logic       read;
      logic       write;
      logic [3:0] address;
      logic [7:0] writedata;
   } tcc_bus_req_s;
endpackage : tcc_pkg
`default_nettype wire

/* logic/tcc_top.sv */
// Input capture and output compare units of a 16-bit timer
//
// Implementation choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "tcc_map.svh"

module tcc_top #(
   parameter int NUM_CMP  = 3,
   parameter bit HAS_ACMP = 1'b1
) (
   input  wire logic               core_clk_in,
   input  wire logic               rstn_in,
   input  wire logic               ce_in,
   input  wire logic [3:0]         avs_address_in,
   input  wire logic               avs_read_in,
   input  wire logic               avs_write_in,
   input  wire logic [7:0]         avs_writedata_in,
   output logic [7:0]              avs_readdata_out,
   output logic                    avs_waitrequest_out,
   input  wire logic [15:0]        counter_value_in,
   input  wire logic               timer_tick_in,
   input  wire logic               counter_top_in,
   input  wire logic               counter_bottom_in,
   input  wire logic               counter_write_in,
   input  wire logic               capture_input_pin_in,
   input  wire logic               comparator_output_in,
   input  wire logic               capture_ack_in,
   input  wire logic [NUM_CMP-1:0] compare_ack_in,
   output logic                    capture_irq_out,
   output logic [NUM_CMP-1:0]      compare_irq_out,
   output logic [NUM_CMP-1:0]      compare_match_out,
   output logic [NUM_CMP-1:0]      compare_output_state_out,
   output logic [15:0]             compare_a_top_out,
   output logic [15:0]             capture_register_out,
   output logic [3:0]              waveform_mode_out
);

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic rst_meta_q;
   logic rst_sync_q;
   logic rst_n;

   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end
   assign rst_n = rst_sync_q;

   // ----------------------------------------------------------------
   // Bus slave: one wait cycle, then access completes
   // ----------------------------------------------------------------
   tcc_pkg::tcc_bus_req_s req;
   logic                  ack_q;
   logic                  acc;
   logic                  wr_acc;
   logic                  rd_acc;
   logic [7:0]            rdata_d;
   logic [7:0]            rdata_q;

   assign req.read      = avs_read_in;
   assign req.write     = avs_write_in;
   assign req.address   = avs_address_in;
   assign req.writedata = avs_writedata_in;

   assign acc    = ce_in && ack_q && (req.read || req.write);
   assign wr_acc = acc && req.write;
   assign rd_acc = acc && req.read;
   assign avs_waitrequest_out = (req.read || req.write) && !ack_q;
   assign avs_readdata_out    = rdata_q;

   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
      end else if (ce_in) begin
         ack_q <= (req.read || req.write) && !ack_q;
      end
   end

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   tcc_pkg::tcc_cap_cfg_s     cfg_q;
   tcc_pkg::tcc_mode_t        mode_q;
   tcc_pkg::tcc_com_t [NUM_CMP-1:0] com_q;
   logic [NUM_CMP:0]          inten_q;
   logic [7:0]                temp_q;
   logic                      pwm_mode;
   logic                      top_upd;
   logic                      icr_top;
   logic                      load_tick;

   // Mode masks as named vectors, one bit per waveform mode
   localparam logic [15:0] PWM_MODES    = `TCC_PWM_MASK;
   localparam logic [15:0] TOPUPD_MODES = `TCC_TOPUPD_MASK;
   localparam logic [15:0] ICRTOP_MODES = `TCC_ICRTOP_MASK;

   assign pwm_mode  = PWM_MODES[mode_q];
   assign top_upd   = TOPUPD_MODES[mode_q];
   assign icr_top   = ICRTOP_MODES[mode_q];
   assign load_tick = timer_tick_in && (top_upd ? counter_top_in : counter_bottom_in);
   assign waveform_mode_out = mode_q;

   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q   <= '0;
         mode_q  <= '0;
         com_q   <= '0;
         inten_q <= '0;
      end else if (wr_acc) begin
         case (req.address)
            `TCC_ADR_CTRL: begin
               cfg_q.filt_en  <= req.writedata[`TCC_CTRL_FILT];
               cfg_q.rise     <= req.writedata[`TCC_CTRL_RISE];
               cfg_q.acmp_sel <= HAS_ACMP && req.writedata[`TCC_CTRL_ACMP];
            end
            `TCC_ADR_MODE:  mode_q  <= req.writedata[3:0];
            `TCC_ADR_COM:   com_q   <= req.writedata[2*NUM_CMP-1:0];
            `TCC_ADR_INTEN: inten_q <= req.writedata[NUM_CMP:0];
            default: ;
         endcase
      end
   end

   // Shared high-byte holding register
   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         temp_q <= `TCC_BYTE_ZERO;
      end else if (rd_acc && req.address == `TCC_ADR_CAP_LO) begin
         temp_q <= capture_register_out[15:8];
      end else if (wr_acc && (req.address == `TCC_ADR_CAP_HI
                              || req.address == `TCC_ADR_CMPA_HI
                              || req.address == `TCC_ADR_CMPB_HI
                              || req.address == `TCC_ADR_CMPC_HI)) begin
         temp_q <= req.writedata;
      end
   end

   // ----------------------------------------------------------------
   // Capture trigger, filter and edge detector
   // ----------------------------------------------------------------
   logic                     trig_src;
   logic [`TCC_FILT_LEN-1:0] samp_q;
   logic                     filt_q;
   logic                     det_in;
   logic                     det_prev_q;
   logic                     cap_edge;
   logic                     cap_evt;
   logic                     cap_flag_q;
   logic                     cap_w1c;

   assign trig_src = cfg_q.acmp_sel ? comparator_output_in : capture_input_pin_in;

   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         samp_q <= '0;
         filt_q <= 1'b0;
      end else if (ce_in) begin
         samp_q <= {samp_q[`TCC_FILT_LEN-2:0], trig_src};
         if (&samp_q == 1'b1 || |samp_q == 1'b0) begin
            filt_q <= samp_q[0];
         end
      end
   end

   assign det_in   = cfg_q.filt_en ? filt_q : samp_q[0];
   assign cap_edge = cfg_q.rise ? (det_in && !det_prev_q) : (!det_in && det_prev_q);
   assign cap_evt  = cap_edge && !icr_top;

   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         det_prev_q <= 1'b0;
      end else if (ce_in) begin
         det_prev_q <= det_in;
      end
   end

   // Capture register: capture wins over a software write
   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         capture_register_out <= `TCC_WORD_ZERO;
      end else if (ce_in && cap_evt) begin
         capture_register_out <= counter_value_in;
      end else if (wr_acc && req.address == `TCC_ADR_CAP_LO && icr_top) begin
         capture_register_out <= {temp_q, req.writedata};
      end
   end

   assign cap_w1c = wr_acc && req.address == `TCC_ADR_FLAGS
                    && req.writedata[`TCC_FLAG_CAP];

   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         cap_flag_q <= 1'b0;
      end else if (ce_in) begin
         if (cap_evt) begin
            cap_flag_q <= 1'b1;
         end else if (cap_w1c || capture_ack_in) begin
            cap_flag_q <= 1'b0;
         end
      end
   end

   assign capture_irq_out = cap_flag_q && inten_q[`TCC_FLAG_CAP];

   // ----------------------------------------------------------------
   // Match blocking after a counter write
   // ----------------------------------------------------------------
   logic block_q;

   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         block_q <= 1'b0;
      end else if (ce_in) begin
         if (counter_write_in) begin
            block_q <= 1'b1;
         end else if (timer_tick_in) begin
            block_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Compare units
   // ----------------------------------------------------------------
   logic [NUM_CMP-1:0][15:0] ocr_q;
   logic [NUM_CMP-1:0][15:0] buf_q;
   logic [NUM_CMP-1:0]       cmp_flag_q;
   logic [NUM_CMP-1:0]       oc_q;

   genvar g;
   generate
      for (g = 0; g < NUM_CMP; g++) begin : g_cmp
         logic       wr_lo;
         logic       w1c;
         logic       hit;
         logic       force_hit;
         logic       act;
         logic [15:0] wval;

         assign wr_lo = wr_acc && req.address == 4'(`TCC_ADR_CMPA_LO + 2 * g);
         assign wval  = {temp_q, req.writedata};
         assign w1c   = wr_acc && req.address == `TCC_ADR_FLAGS
                        && req.writedata[`TCC_FLAG_CMP0 + g];
         assign hit   = timer_tick_in && !block_q
                        && counter_value_in == ocr_q[g];
         assign force_hit = wr_acc && req.address == `TCC_ADR_FORCE
                            && req.writedata[g] && !pwm_mode;
         assign act   = ce_in && (hit || force_hit);
         assign compare_match_out[g] = ce_in && hit;

         always_ff @(posedge core_clk_in or negedge rst_n) begin
            if (!rst_n) begin
               buf_q[g] <= `TCC_WORD_ZERO;
            end else if (wr_lo && pwm_mode) begin
               buf_q[g] <= wval;
            end
         end

         always_ff @(posedge core_clk_in or negedge rst_n) begin
            if (!rst_n) begin
               ocr_q[g] <= `TCC_WORD_ZERO;
            end else if (wr_lo && !pwm_mode) begin
               ocr_q[g] <= wval;
            end else if (ce_in && pwm_mode && load_tick) begin
               ocr_q[g] <= buf_q[g];
            end
         end

         always_ff @(posedge core_clk_in or negedge rst_n) begin
            if (!rst_n) begin
               cmp_flag_q[g] <= 1'b0;
            end else if (ce_in) begin
               if (hit) begin
                  cmp_flag_q[g] <= 1'b1;
               end else if (w1c || compare_ack_in[g]) begin
                  cmp_flag_q[g] <= 1'b0;
               end
            end
         end

         // Output state; mode changes never touch it
         always_ff @(posedge core_clk_in or negedge rst_n) begin
            if (!rst_n) begin
               oc_q[g] <= 1'b0;
            end else if (act && !pwm_mode) begin
               case (com_q[g])
                  `TCC_COM_TOGGLE: oc_q[g] <= !oc_q[g];
                  `TCC_COM_CLEAR:  oc_q[g] <= 1'b0;
                  `TCC_COM_SET:    oc_q[g] <= 1'b1;
                  default:         oc_q[g] <= oc_q[g];
               endcase
            end else if (ce_in && pwm_mode) begin
               if (hit) begin
                  case (com_q[g])
                     `TCC_COM_CLEAR: oc_q[g] <= 1'b0;
                     `TCC_COM_SET:   oc_q[g] <= 1'b1;
                     default:        oc_q[g] <= oc_q[g];
                  endcase
               end else if (timer_tick_in && counter_bottom_in) begin
                  case (com_q[g])
                     `TCC_COM_CLEAR: oc_q[g] <= 1'b1;
                     `TCC_COM_SET:   oc_q[g] <= 1'b0;
                     default:        oc_q[g] <= oc_q[g];
                  endcase
               end
            end
         end

         assign compare_irq_out[g] = cmp_flag_q[g] && inten_q[`TCC_FLAG_CMP0 + g];
      end
   endgenerate

   assign compare_output_state_out = oc_q;
   assign compare_a_top_out        = ocr_q[0];

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   logic [15:0] cmp_view;
   logic        cmp_rd;
   int unsigned cidx;

   always_comb begin
      cmp_rd   = req.address >= `TCC_ADR_CMPA_LO && req.address <= `TCC_ADR_CMPC_HI;
      cidx     = 32'(req.address - `TCC_ADR_CMPA_LO) >> 1;
      cmp_view = `TCC_WORD_ZERO;
      if (cmp_rd && cidx < NUM_CMP) begin
         cmp_view = pwm_mode ? buf_q[cidx] : ocr_q[cidx];
      end
      rdata_d = `TCC_BYTE_ZERO;
      case (req.address)
         `TCC_ADR_CAP_LO: rdata_d = capture_register_out[7:0];
         `TCC_ADR_CAP_HI: rdata_d = temp_q;
         `TCC_ADR_CTRL:   rdata_d = 8'({cfg_q.acmp_sel, cfg_q.rise, cfg_q.filt_en});
         `TCC_ADR_MODE:   rdata_d = 8'(mode_q);
         `TCC_ADR_COM:    rdata_d = 8'(com_q);
         `TCC_ADR_FLAGS:  rdata_d = 8'({cmp_flag_q, cap_flag_q});
         `TCC_ADR_INTEN:  rdata_d = 8'(inten_q);
         default: begin
            if (cmp_rd) begin
               rdata_d = req.address[0] ? cmp_view[15:8] : cmp_view[7:0];
            end
         end
      endcase
   end

   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= `TCC_BYTE_ZERO;
      end else if (ce_in && req.read && !ack_q) begin
         rdata_q <= rdata_d;
      end
   end

endmodule : tcc_top
`default_nettype wire

/* testbench/tcc_chk.sv */
// Port-level assertions for the capture/compare block
`timescale 1ns/100ps
`default_nettype none
module tcc_chk #(
   parameter int NUM_CMP = 3
) (
   input wire logic               core_clk_in,
   input wire logic               rstn_in,
   input wire logic               ce_in,
   input wire logic               avs_read_in,
   input wire logic               avs_write_in,
   input wire logic               avs_waitrequest_out,
   input wire logic [15:0]        counter_value_in,
   input wire logic               timer_tick_in,
   input wire logic               counter_top_in,
   input wire logic               counter_bottom_in,
   input wire logic               counter_write_in,
   input wire logic               capture_ack_in,
   input wire logic [NUM_CMP-1:0] compare_ack_in,
   input wire logic               capture_irq_out,
   input wire logic [NUM_CMP-1:0] compare_irq_out,
   input wire logic [NUM_CMP-1:0] compare_match_out,
   input wire logic [NUM_CMP-1:0] compare_output_state_out,
   input wire logic [15:0]        compare_a_top_out,
   input wire logic [15:0]        capture_register_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rstn_in);
   logic req;
   logic blk_q;
   assign req = avs_read_in | avs_write_in;
   // Counter written since the last tick
   always_ff @(posedge core_clk_in or negedge rstn_in)
      if (!rstn_in)
         blk_q <= 1'h0;
      else if (timer_tick_in)
         blk_q <= 1'h0;
      else if (counter_write_in)
         blk_q <= 1'h1;
   AST_WAIT_FIRST: assert property (req && !$past(req) |-> avs_waitrequest_out)
      else $error("no wait cycle on new request");
   AST_WAIT_ONE: assert property (req && avs_waitrequest_out && ce_in |=> !avs_waitrequest_out)
      else $error("more than one wait cycle");
   AST_MATCH_A: assert property (compare_match_out[0] |->
      timer_tick_in && counter_value_in == compare_a_top_out)
      else $error("match A without equal counter on tick");
   AST_MATCH_BLOCK: assert property (blk_q |-> !(|compare_match_out))
      else $error("match after counter write");
   AST_CIRQ_RISE: assert property ($rose(capture_irq_out) |->
      $changed(capture_register_out) || $past(avs_write_in))
      else $error("capture irq without capture");
   AST_CACK: assert property (capture_ack_in && !avs_write_in |=>
      !capture_irq_out || $changed(capture_register_out))
      else $error("capture ack left irq");
   AST_KACK: assert property (compare_ack_in[0] && !compare_match_out[0] &&
      !avs_write_in |=> !compare_irq_out[0])
      else $error("compare ack left irq");
   AST_KIRQ_RISE: assert property ($rose(compare_irq_out[0]) |->
      $past(compare_match_out[0]) || $past(avs_write_in))
      else $error("compare irq without match");
   AST_RST_STATE: assert property (disable iff (1'h0)
      !rstn_in |-> !(|compare_output_state_out))
      else $error("output state not cleared in reset");
   AST_STATE_CAUSE: assert property ($changed(compare_output_state_out) |->
      $past(avs_write_in) || $past(avs_write_in, 2) || $past(|compare_match_out)
      || $past(counter_bottom_in || counter_top_in))
      else $error("output state changed without cause");
   AST_TOPA_CHG: assert property ($changed(compare_a_top_out) |->
      $past(avs_write_in) || $past(counter_bottom_in || counter_top_in))
      else $error("compare A changed without write or TOP/BOTTOM");
   CV_MATCH: cover property (compare_match_out[0]);
   CV_CAP: cover property ($rose(capture_irq_out));
   CV_STATE: cover property ($changed(compare_output_state_out));
endmodule : tcc_chk
bind tcc_top tcc_chk #(.NUM_CMP(NUM_CMP)) i_chk (.*);
`default_nettype wire

/* testbench/tcc_cpu.sv */
// CPU bus master model issuing byte transfers
`timescale 1ns/100ps
`default_nettype none
module tcc_cpu (
   input  wire logic       clk_in,
   input  wire logic       wait_in,
   input  wire logic [7:0] rdata_in,
   output var logic        rd_out,
   output var logic        wr_out,
   output var logic [3:0]  adr_out,
   output var logic [7:0]  wdata_out
);
   int tmo = 0;
   initial begin
      rd_out = 1'h0;
      wr_out = 1'h0;
      adr_out = 4'h0;
      wdata_out = 8'h00;
   end
   // Request held until waitrequest seen low or 64 wait cycles pass
   task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d,
                       output logic [7:0] q);
      int n;
      n = 0;
      @(posedge clk_in);
      rd_out <= ~w;
      wr_out <= w;
      adr_out <= a;
      wdata_out <= d;
      @(posedge clk_in);
      while (wait_in !== 1'h0 && n < 64) begin
         n++;
         @(posedge clk_in);
      end
      if (n == 64)
         tmo++;
      // Completion edge: take read data, then release
      q = rdata_in;
      rd_out <= 1'h0;
      wr_out <= 1'h0;
   endtask : xfer
endmodule : tcc_cpu
`default_nettype wire

/* testbench/tcc_top_tb.sv */
// Self-checking bench for the capture/compare block
`timescale 1ns/100ps
`default_nettype none
`include "tcc_map.svh"
module tcc_top_tb;
   logic        clk, rstn, ce, tick, top, bot, cwr, pin, acmp, cack, rd, wr, wt, st, cirq;
   logic [2:0]  kack, kirq, kmat, kst, m;
   logic [3:0]  adr, wm;
   logic [7:0]  wd, rdat, q;
   logic [15:0] cnt, atop, capr, v, v1;
   logic [1:0]  cseq [5] = '{2'h3, 2'h0, 2'h1, 2'h3, 2'h2};
   int          num_errors = 0;
   int          n_compared = 0;
   int          lat;
   tcc_top #(.NUM_CMP(3)) i_dut (
      .core_clk_in(clk), .rstn_in(rstn), .ce_in(ce), .avs_address_in(adr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
      .avs_readdata_out(rdat), .avs_waitrequest_out(wt), .counter_value_in(cnt),
      .timer_tick_in(tick), .counter_top_in(top), .counter_bottom_in(bot),
      .counter_write_in(cwr), .capture_input_pin_in(pin), .comparator_output_in(acmp),
      .capture_ack_in(cack), .compare_ack_in(kack), .capture_irq_out(cirq),
      .compare_irq_out(kirq), .compare_match_out(kmat), .compare_output_state_out(kst),
      .compare_a_top_out(atop), .capture_register_out(capr), .waveform_mode_out(wm));
   tcc_cpu i_cpu (.clk_in(clk), .wait_in(wt), .rdata_in(rdat), .rd_out(rd),
                  .wr_out(wr), .adr_out(adr), .wdata_out(wd));
   initial begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end
   // ----------------------------
   // Helpers
   // ----------------------------
   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic wr8(input logic [3:0] a, input logic [7:0] d);
      i_cpu.xfer(1'h1, a, d, q);
      // Let the write settle before anything looks at it
      @(negedge clk);
   endtask : wr8
   task automatic rd8(input logic [3:0] a, input logic [7:0] e, input string nm);
      i_cpu.xfer(1'h0, a, 8'h00, q);
      chk(nm, {8'h00, q}, {8'h00, e});
   endtask : rd8
   // New counter value with a trigger change; edges until capture
   task automatic trig(input logic src, input logic lv);
      logic [15:0] old;
      old = capr;
      @(posedge clk);
      cnt <= old ^ (16'h0001 | 16'($urandom));
      if (src)
         acmp <= lv;
      else
         pin <= lv;
      for (lat = 0; lat < 12; lat++) begin
         @(negedge clk);
         if (capr !== old)
            break;
      end
   endtask : trig
   task automatic tk;
      @(posedge clk);
      tick <= 1'h1;
      @(negedge clk);
      m = kmat;
      @(posedge clk);
      tick <= 1'h0;
   endtask : tk
   task automatic final_report;
      num_errors += i_cpu.tmo;
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : final_report
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      final_report();
   end
   // ----------------------------
   // Main sequence
   // ----------------------------
   initial begin
      rstn = 1'h1;
      ce = 1'h1;
      {tick, top, bot, cwr, pin, acmp, cack} = 7'h00;
      kack = 3'h0;
      cnt = 16'h0000;
      // Reset edge before the first clock edge
      #1 rstn = 1'h0;
      void'($urandom(25360));
      repeat (6) @(posedge clk);
      rstn <= 1'h1;
      repeat (3) @(posedge clk);
      chk("ostate", 16'(kst), 16'h0000);
      wr8(`TCC_ADR_CTRL, 8'h02);
      trig(1'h0, 1'h1);
      chk("cap", capr, cnt);
      chk("lat", 16'(lat), 16'h0002);
      rd8(`TCC_ADR_FLAGS, 8'h01, "flag");
      v1 = cnt;
      trig(1'h0, 1'h0);
      chk("nofall", 16'(lat), 16'h000C);
      rd8(`TCC_ADR_CAP_LO, v1[7:0], "caplo");
      wr8(`TCC_ADR_CTRL, 8'h00);
      trig(1'h0, 1'h1);
      chk("norise", 16'(lat), 16'h000C);
      trig(1'h0, 1'h0);
      rd8(`TCC_ADR_CAP_HI, v1[15:8], "caphi");
      chk("overwr", capr, cnt);
      wr8(`TCC_ADR_FLAGS, 8'h01);
      rd8(`TCC_ADR_FLAGS, 8'h00, "w1c");
      wr8(`TCC_ADR_INTEN, 8'h01);
      wr8(`TCC_ADR_CTRL, 8'h02);
      trig(1'h0, 1'h1);
      chk("cirq", 16'(cirq), 16'h0001);
      @(posedge clk);
      cack <= 1'h1;
      @(posedge clk);
      cack <= 1'h0;
      @(negedge clk);
      chk("cack", 16'(cirq), 16'h0000);
      wr8(`TCC_ADR_INTEN, 8'h00);
      trig(1'h0, 1'h0);
      wr8(`TCC_ADR_CTRL, 8'h03);
      v = capr;
      @(posedge clk);
      pin <= 1'h1;
      repeat (3) @(posedge clk);
      pin <= 1'h0;
      repeat (12) @(posedge clk);
      chk("glitch", capr, v);
      trig(1'h0, 1'h1);
      chk("filt", 16'(lat), 16'h0006);
      chk("fcap", capr, cnt);
      wr8(`TCC_ADR_MODE, 8'h0C);
      v = 16'($urandom);
      wr8(`TCC_ADR_CAP_HI, v[15:8]);
      wr8(`TCC_ADR_CAP_LO, v[7:0]);
      chk("capw", capr, v);
      trig(1'h0, 1'h0);
      trig(1'h0, 1'h1);
      chk("capoff", capr, v);
      wr8(`TCC_ADR_MODE, 8'h00);
      wr8(`TCC_ADR_CAP_HI, ~v[15:8]);
      wr8(`TCC_ADR_CAP_LO, ~v[7:0]);
      chk("capro", capr, v);
      wr8(`TCC_ADR_CTRL, 8'h06);
      wr8(`TCC_ADR_FLAGS, 8'h01);
      trig(1'h0, 1'h0);
      trig(1'h0, 1'h1);
      chk("pinoff", 16'(lat), 16'h000C);
      trig(1'h1, 1'h1);
      chk("acap", capr, cnt);
      wr8(`TCC_ADR_FLAGS, 8'h0F);
      wr8(`TCC_ADR_INTEN, 8'h0E);
      for (int i = 0; i < 3; i++) begin
         v = 16'($urandom);
         if (i == 0)
            v1 = v;
         wr8(4'(3 + 2 * i), v[15:8]);
         wr8(4'(2 + 2 * i), v[7:0]);
         rd8(4'(2 + 2 * i), v[7:0], "klo");
         rd8(4'(3 + 2 * i), v[15:8], "khi");
         @(posedge clk);
         cnt <= v;
         cwr <= 1'h1;
         @(posedge clk);
         cwr <= 1'h0;
         tk();
         chk("blk", 16'(m), 16'h0000);
         tk();
         chk("kmat", 16'(m), 16'(1 << i));
         @(negedge clk);
         chk("kirq", 16'(kirq), 16'(1 << i));
         @(posedge clk);
         kack[i] <= 1'h1;
         @(posedge clk);
         kack[i] <= 1'h0;
         @(negedge clk);
         chk("kack", 16'(kirq), 16'h0000);
      end
      chk("atop", atop, v1);
      st = 1'h0;
      foreach (cseq[j]) begin
         wr8(`TCC_ADR_COM, {6'h00, cseq[j]});
         wr8(`TCC_ADR_FORCE, 8'h01);
         case (cseq[j])
            2'h1: st = ~st;
            2'h2: st = 1'h0;
            2'h3: st = 1'h1;
            default: st = st;
         endcase
         repeat (2) @(negedge clk);
         chk("force", 16'(kst[0]), 16'(st));
      end
      rd8(`TCC_ADR_FLAGS, 8'h00, "fflag");
      wr8(`TCC_ADR_COM, 8'h01);
      @(posedge clk);
      cnt <= atop;
      tk();
      @(negedge clk);
      chk("mtog", 16'(kst[0]), 16'h0001);
      wr8(`TCC_ADR_MODE, 8'h05);
      chk("keep", 16'(kst[0]), 16'h0001);
      chk("wmode", 16'(wm), 16'h0005);
      v1 = atop;
      v = ~atop;
      wr8(`TCC_ADR_CMPA_HI, v[15:8]);
      wr8(`TCC_ADR_CMPA_LO, v[7:0]);
      chk("buf", atop, v1);
      rd8(`TCC_ADR_CMPA_LO, v[7:0], "bufrd");
      wr8(`TCC_ADR_FORCE, 8'h01);
      @(posedge clk);
      bot <= 1'h1;
      tk();
      bot <= 1'h0;
      @(negedge clk);
      chk("upd", atop, v);
      chk("pwmf", 16'(kst[0]), 16'h0001);
      wr8(`TCC_ADR_MODE, 8'h01);
      wr8(`TCC_ADR_CMPA_HI, v1[15:8]);
      wr8(`TCC_ADR_CMPA_LO, v1[7:0]);
      chk("buftop", atop, v);
      @(posedge clk);
      top <= 1'h1;
      tk();
      top <= 1'h0;
      @(negedge clk);
      chk("updtop", atop, v1);
      final_report();
   end
endmodule : tcc_top_tb
`default_nettype wire
